// ### hdl/mlf_cfg.svh
// Offsets, field positions, reset values and timing counts for the lock fault policy.
// Assumes a 50 MHz system clock and a 32-bit APB register port.
`ifndef MLF_CFG_SVH
`define MLF_CFG_SVH

// =============================================================
// Register indices and byte addresses
`define MLF_IDX_CFG_FIRST    12'h090
`define MLF_IDX_CFG_SECOND   12'h092
`define MLF_IDX_STATUS       12'h094
`define MLF_IDX_CONTROL      12'h095
`define MLF_ADDR_CFG_FIRST   (`MLF_IDX_CFG_FIRST << 2)
`define MLF_ADDR_CFG_SECOND  (`MLF_IDX_CFG_SECOND << 2)
`define MLF_ADDR_STATUS      (`MLF_IDX_STATUS << 2)
`define MLF_ADDR_CONTROL     (`MLF_IDX_CONTROL << 2)

// =============================================================
// First configuration register fields
`define MLF_F1_INTERVAL_LSB  7
`define MLF_F1_MODE_LSB      3
`define MLF_F1_IPD_TMO_EN    2
`define MLF_F1_IPD_FRQ_EN    1
`define MLF_F1_SAT_EN        0
`define MLF_F1_RESET         11'h000

// =============================================================
// Second configuration register fields
`define MLF_F2_SPEED_EN      30
`define MLF_F2_BEMF_EN       29
`define MLF_F2_ABSENT_EN     28
`define MLF_F2_LIMIT_LSB     0
`define MLF_F2_RESET         31'h00000000

// =============================================================
// Control register bits
`define MLF_CTL_CLR_LOCK     0
`define MLF_CTL_CLR_IPD      1

// =============================================================
// Lock response mode codes
`define MLF_MODE_LATCH_HS    4'h2
`define MLF_MODE_LATCH_LS    4'h3
`define MLF_MODE_RETRY_TS    4'h4
`define MLF_MODE_RETRY_TS2   4'h5
`define MLF_MODE_RETRY_HS    4'h6
`define MLF_MODE_RETRY_LS    4'h7
`define MLF_MODE_REPORT      4'h8

// =============================================================
// Timing
`define MLF_CLK_MHZ          50
`define MLF_TICK_US          1000
`define MLF_TICK_CYCLES      (`MLF_TICK_US * `MLF_CLK_MHZ)
`define MLF_RETRY_C0_MS      14'd300
`define MLF_RETRY_C1_MS      14'd500
`define MLF_RETRY_STEP_MS    14'd1000

`endif

// ### hdl/mlf_pkg.sv
// Types shared by the lock fault policy block.
// Assumes mlf_cfg.svh is compiled alongside.
package mlf_pkg;

	typedef enum logic [1:0] {MLF_GATE_RUN, MLF_GATE_TRISTATE, MLF_GATE_BRAKE_HS, MLF_GATE_BRAKE_LS} mlf_gate_t;
	typedef enum logic [1:0] {MLF_ST_IDLE, MLF_ST_RETRY, MLF_ST_LATCHED, MLF_ST_REPORT} mlf_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mlf_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} mlf_apb_rsp_t;

	typedef struct packed {
		logic abnormal_speed;
		logic abnormal_backemf;
		logic absent_motor;
		logic ipd_timeout;
		logic ipd_freq;
		logic current_sat;
		logic speed_sat;
	} mlf_events_t;

endpackage

// ### hdl/mlf_top.sv
// Motor lock fault response policy with APB register access.
// Assumes event inputs are synchronous to clk and lock detectors live outside.
//
// Chosen here: register access over APB.
`include "mlf_cfg.svh"

module mlf_top #(
	parameter int unsigned TICK_CYCLES = `MLF_TICK_CYCLES
) (
	input  wire logic                 clk,                 // 50 MHz system clock
	input  wire logic                 rst_n,               // Async reset, active low
	input  wire mlf_pkg::mlf_apb_req_t apb_req,            // APB request
	output mlf_pkg::mlf_apb_rsp_t      apb_rsp,             // APB response
	input  wire mlf_pkg::mlf_events_t  events,              // Detector event inputs
	output mlf_pkg::mlf_gate_t         gate_mode,           // Gate driver state
	output logic                       fault_indicator_low, // Fault pin, active low
	output logic                       current_sat_flag,    // Gated current loop saturation
	output logic                       speed_sat_flag       // Gated speed loop saturation
);
	import mlf_pkg::*;

	// =============================================================
	// State
	typedef struct packed {
		mlf_state_t   st;
		mlf_gate_t    gate;
		logic         fault_n;
		logic         cur_sat;
		logic         spd_sat;
		logic [2:0]   retries;
		logic [15:0]  tick_cnt;
		logic [13:0]  ms_cnt;
		logic         ipd_tmo;
		logic         ipd_frq;
		logic [10:0]  cfg1;
		logic [30:0]  cfg2;
		mlf_apb_rsp_t rsp;
	} mlf_regs_t;

	mlf_regs_t cur;
	mlf_regs_t next_cur;

	// =============================================================
	// Helpers
	function automatic logic [13:0] interval_ms(input logic [3:0] code);
		logic [13:0] ms;
		ms = 14'h0000;
		unique case (code)
			4'h0:    ms = `MLF_RETRY_C0_MS;
			4'h1:    ms = `MLF_RETRY_C1_MS;
			default: ms = 14'(({10'h000, code} - 14'h0001) * `MLF_RETRY_STEP_MS);
		endcase
		return ms;
	endfunction

	logic [3:0]  mode;
	logic [3:0]  ivl_code;
	logic [2:0]  limit;
	logic        lock_evt;
	logic        acc;
	logic        wr;
	logic [11:0] idx;
	logic        clr_lock;
	logic        clr_ipd;
	logic        tick;
	logic        ivl_done;

	assign mode     = cur.cfg1[`MLF_F1_MODE_LSB +: 4];
	assign ivl_code = cur.cfg1[`MLF_F1_INTERVAL_LSB +: 4];
	assign limit    = cur.cfg2[`MLF_F2_LIMIT_LSB +: 3];
	assign lock_evt = (events.abnormal_speed & cur.cfg2[`MLF_F2_SPEED_EN])
	                | (events.abnormal_backemf & cur.cfg2[`MLF_F2_BEMF_EN])
	                | (events.absent_motor & cur.cfg2[`MLF_F2_ABSENT_EN]);
	// Access completes at the edge where the registered pready is seen high
	assign acc      = apb_req.psel & apb_req.penable & cur.rsp.pready;
	assign wr       = acc & apb_req.pwrite;
	assign idx      = {2'b00, apb_req.paddr[11:2]};
	assign clr_lock = wr & (idx == `MLF_IDX_CONTROL) & apb_req.pwdata[`MLF_CTL_CLR_LOCK];
	assign clr_ipd  = wr & (idx == `MLF_IDX_CONTROL) & apb_req.pwdata[`MLF_CTL_CLR_IPD];
	assign tick     = (cur.tick_cnt == 16'(TICK_CYCLES - 1));
	assign ivl_done = tick & (cur.ms_cnt + 14'h0001 >= interval_ms(ivl_code));

	// =============================================================
	// Next state
	always_comb begin
		next_cur = cur;

		// Sticky faults; a new event beats a clear in the same cycle
		if (clr_ipd) begin
			next_cur.ipd_tmo = 1'b0;
			next_cur.ipd_frq = 1'b0;
		end
		if (events.ipd_timeout & cur.cfg1[`MLF_F1_IPD_TMO_EN])
			next_cur.ipd_tmo = 1'b1;
		if (events.ipd_freq & cur.cfg1[`MLF_F1_IPD_FRQ_EN])
			next_cur.ipd_frq = 1'b1;
		next_cur.cur_sat = events.current_sat & cur.cfg1[`MLF_F1_SAT_EN];
		next_cur.spd_sat = events.speed_sat & cur.cfg1[`MLF_F1_SAT_EN];

		// Software clear drops the lock fault and restores the retry allowance
		if (clr_lock) begin
			next_cur.st      = MLF_ST_IDLE;
			next_cur.gate    = MLF_GATE_RUN;
			next_cur.retries = 3'h0;
		end

		// Retry interval timer runs only while waiting out a fault
		if (cur.st == MLF_ST_RETRY && !clr_lock) begin
			next_cur.tick_cnt = tick ? 16'h0000 : cur.tick_cnt + 16'h0001;
			if (tick)
				next_cur.ms_cnt = cur.ms_cnt + 14'h0001;
			if (ivl_done) begin
				next_cur.st      = MLF_ST_IDLE;
				next_cur.gate    = MLF_GATE_RUN;
				next_cur.retries = cur.retries + 3'h1;
			end
		end else begin
			next_cur.tick_cnt = 16'h0000;
			next_cur.ms_cnt   = 14'h0000;
		end

		// Lock response, taken from idle (also right after a clear)
		if (lock_evt && (cur.st == MLF_ST_IDLE || clr_lock)) begin
			unique case (mode)
				4'h0, 4'h1: begin
					next_cur.st   = MLF_ST_LATCHED;
					next_cur.gate = MLF_GATE_TRISTATE;
				end
				`MLF_MODE_LATCH_HS: begin
					next_cur.st   = MLF_ST_LATCHED;
					next_cur.gate = MLF_GATE_BRAKE_HS;
				end
				`MLF_MODE_LATCH_LS: begin
					next_cur.st   = MLF_ST_LATCHED;
					next_cur.gate = MLF_GATE_BRAKE_LS;
				end
				`MLF_MODE_RETRY_TS, `MLF_MODE_RETRY_TS2: begin
					next_cur.gate = MLF_GATE_TRISTATE;
					if (next_cur.retries < limit)
						next_cur.st = MLF_ST_RETRY;
					else
						next_cur.st = MLF_ST_LATCHED;
				end
				`MLF_MODE_RETRY_HS: begin
					next_cur.gate = MLF_GATE_BRAKE_HS;
					next_cur.st   = (next_cur.retries < limit) ? MLF_ST_RETRY : MLF_ST_LATCHED;
				end
				`MLF_MODE_RETRY_LS: begin
					if (next_cur.retries < limit) begin
						next_cur.st   = MLF_ST_RETRY;
						next_cur.gate = MLF_GATE_TRISTATE;
					end else begin
						next_cur.st   = MLF_ST_LATCHED;
						next_cur.gate = MLF_GATE_BRAKE_LS;
					end
				end
				`MLF_MODE_REPORT: begin
					next_cur.st   = MLF_ST_REPORT;
					next_cur.gate = MLF_GATE_RUN;
				end
				default: ; // Lock detection disabled
			endcase
		end

		next_cur.fault_n = !((next_cur.st != MLF_ST_IDLE) | next_cur.ipd_tmo | next_cur.ipd_frq);

		// APB slave: one wait state, then registered answer
		next_cur.rsp.pready  = apb_req.psel & apb_req.penable & !cur.rsp.pready;
		next_cur.rsp.pslverr = 1'b0;
		next_cur.rsp.prdata  = 32'h00000000;
		if (apb_req.psel & apb_req.penable & !cur.rsp.pready) begin
			unique case (idx)
				`MLF_IDX_CFG_FIRST:  next_cur.rsp.prdata = {21'h000000, cur.cfg1};
				`MLF_IDX_CFG_SECOND: next_cur.rsp.prdata = {1'b0, cur.cfg2};
				`MLF_IDX_STATUS:     next_cur.rsp.prdata = {18'h00000, cur.gate, 1'b0, cur.retries,
				                                            1'b0, cur.spd_sat, cur.cur_sat, cur.ipd_frq,
				                                            cur.ipd_tmo, cur.st, !cur.fault_n};
				`MLF_IDX_CONTROL:    next_cur.rsp.prdata = 32'h00000000;
				default:             next_cur.rsp.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (idx)
				`MLF_IDX_CFG_FIRST:  next_cur.cfg1 = apb_req.pwdata[10:0];
				`MLF_IDX_CFG_SECOND: next_cur.cfg2 = apb_req.pwdata[30:0];
				default: ;
			endcase
		end
	end

	// =============================================================
	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.st       <= MLF_ST_IDLE;
			cur.gate     <= MLF_GATE_RUN;
			cur.fault_n  <= 1'b1;
			cur.cur_sat  <= 1'b0;
			cur.spd_sat  <= 1'b0;
			cur.retries  <= 3'h0;
			cur.tick_cnt <= 16'h0000;
			cur.ms_cnt   <= 14'h0000;
			cur.ipd_tmo  <= 1'b0;
			cur.ipd_frq  <= 1'b0;
			cur.cfg1     <= `MLF_F1_RESET;
			cur.cfg2     <= `MLF_F2_RESET;
			cur.rsp      <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign apb_rsp             = cur.rsp;
	assign gate_mode           = cur.gate;
	assign fault_indicator_low = cur.fault_n;
	assign current_sat_flag    = cur.cur_sat;
	assign speed_sat_flag      = cur.spd_sat;

endmodule // mlf_top

// ### verif/mlf_top_checker.sv
// Port-level assertions for the lock fault policy block.
// Assumes mlf_pkg is compiled first; bound into every mlf_top.
// ====
// Checker
module mlf_top_checker
	import mlf_pkg::*;
(
	input wire logic                  clk,                 // Clock
	input wire logic                  rst_n,               // Reset
	input wire mlf_pkg::mlf_apb_req_t apb_req,             // Bus request
	input wire mlf_pkg::mlf_apb_rsp_t apb_rsp,             // Bus answer
	input wire mlf_pkg::mlf_events_t  events,              // Detectors
	input wire mlf_pkg::mlf_gate_t    gate_mode,           // Gate state
	input wire logic                  fault_indicator_low, // Fault pin
	input wire logic                  current_sat_flag,    // Current sat
	input wire logic                  speed_sat_flag       // Speed sat
);
	timeunit 1ns;
	timeprecision 1ns;
	wire any_lock = events.abnormal_speed | events.abnormal_backemf | events.absent_motor;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rdy_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
	property p_rdy_cause; apb_rsp.pready |-> $past(apb_req.psel & apb_req.penable); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
	property p_err_qual; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
	a_err_qual: assert property (p_err_qual) else $error("pslverr alone");
	property p_hs; gate_mode == MLF_GATE_BRAKE_HS && $past(gate_mode) == MLF_GATE_RUN |-> $past(any_lock); endproperty
	a_hs: assert property (p_hs) else $error("high brake uncaused");
	property p_ls; gate_mode == MLF_GATE_BRAKE_LS && $past(gate_mode) == MLF_GATE_RUN |-> $past(any_lock); endproperty
	a_ls: assert property (p_ls) else $error("low brake uncaused");
	property p_flt; $fell(fault_indicator_low) |-> $past(any_lock | events.ipd_timeout | events.ipd_freq); endproperty
	a_flt: assert property (p_flt) else $error("fault uncaused");
	property p_gate_flt; gate_mode != MLF_GATE_RUN |-> !fault_indicator_low; endproperty
	a_gate_flt: assert property (p_gate_flt) else $error("gates off, no fault");
	property p_cur; current_sat_flag |-> $past(events.current_sat); endproperty
	a_cur: assert property (p_cur) else $error("current flag uncaused");
	property p_spd; speed_sat_flag |-> $past(events.speed_sat); endproperty
	a_spd: assert property (p_spd) else $error("speed flag uncaused");
endmodule // mlf_top_checker

bind mlf_top mlf_top_checker u_chk (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.events(events), .gate_mode(gate_mode), .fault_indicator_low(fault_indicator_low),
	.current_sat_flag(current_sat_flag), .speed_sat_flag(speed_sat_flag));

// ### verif/mlf_gate_model.sv
// Three-phase gate stage seen from the policy block.
// Assumes gate_mode comes straight from mlf_top.
module mlf_gate_model
	import mlf_pkg::*;
(
	input  wire mlf_pkg::mlf_gate_t gate_mode, // Commanded state
	output logic [2:0]              hs_on,     // High-side FETs on
	output logic [2:0]              ls_on      // Low-side FETs on
);
	timeunit 1ns;
	timeprecision 1ns;
	// Run shown as all off: the modulator is not modelled
	assign hs_on = {3{gate_mode == MLF_GATE_BRAKE_HS}};
	assign ls_on = {3{gate_mode == MLF_GATE_BRAKE_LS}};
endmodule // mlf_gate_model

// ### verif/motor_lock_fault_policy_test.sv
// Self-checking bench for the lock fault policy block.
// Assumes mlf_cfg.svh on the include path and a shortened tick.
`include "mlf_cfg.svh"
module motor_lock_fault_policy_test
	import mlf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A1 = `MLF_ADDR_CFG_FIRST;
	localparam logic [11:0] A2 = `MLF_ADDR_CFG_SECOND;
	localparam logic [11:0] AS = `MLF_ADDR_STATUS;
	localparam logic [11:0] AC = `MLF_ADDR_CONTROL;
	logic         clk, rst_n, flt, csf, ssf, err;
	mlf_apb_req_t req;
	mlf_apb_rsp_t rsp;
	mlf_events_t  ev;
	mlf_gate_t    gm;
	logic [2:0]   hs, ls;
	logic [31:0]  rd, seed;
	int           n_errors, n_compared;

	// Four-cycle tick keeps the 300 ms code at 1200 cycles
	mlf_top #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .events(ev),
		.gate_mode(gm), .fault_indicator_low(flt), .current_sat_flag(csf), .speed_sat_flag(ssf));
	mlf_gate_model u_gate (.gate_mode(gm), .hs_on(hs), .ls_on(ls));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// ====
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic mlf_gate_t exp_gate(input logic [3:0] m);
		case (m)
			0, 1, 4, 5: return MLF_GATE_TRISTATE;
			2, 6: return MLF_GATE_BRAKE_HS;
			3, 7: return MLF_GATE_BRAKE_LS;
			default: return MLF_GATE_RUN;
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// One-cycle detector pulse, then let the response settle
	task automatic lock_ev(input logic [2:0] src);
		@(posedge clk);
		ev <= {src, 4'h0};
		@(posedge clk);
		ev <= '0;
		cyc(3);
	endtask
	// ====
	// Scenarios
	initial begin
		rst_n = 0;
		req = '0;
		ev = '0;
		seed = 32'hDB6AE033;
		cyc(2);
		rst_n <= 1;
		apb(0, A1, 0);
		chk(rd, 0);
		seed = lfsr(seed);
		apb(1, A2, seed);
		apb(0, A2, 0);
		chk(rd, seed & 32'h7FFFFFFF);
		apb(0, 12'hFFC, 0);
		chk(err, 1);
		apb(1, A2, 0);
		apb(1, A1, 2 << 3);
		lock_ev(3'h7);
		chk(gm, MLF_GATE_RUN);
		apb(1, A2, 32'h70000000);
		for (int m = 0; m < 16; m++) begin
			seed = lfsr(seed);
			apb(1, A1, m << 3);
			lock_ev(3'h1 << (seed % 3));
			chk(gm, exp_gate(m));
			chk(flt, m > 8);
			chk(hs, {3{exp_gate(m) == MLF_GATE_BRAKE_HS}});
			chk(ls, {3{exp_gate(m) == MLF_GATE_BRAKE_LS}});
			apb(1, AC, 1);
			cyc(2);
			chk(flt, 1);
		end
		// Limit 1: one retry, then latch with low-side brake
		apb(1, A2, 32'h40000001);
		apb(1, A1, 7 << 3);
		lock_ev(3'h4);
		apb(0, AS, 0);
		chk(rd[2:1], 1);
		cyc(1100);
		chk(gm, MLF_GATE_TRISTATE);
		cyc(150);
		chk(gm, MLF_GATE_RUN);
		lock_ev(3'h4);
		chk(gm, MLF_GATE_BRAKE_LS);
		cyc(1300);
		chk(flt, 0);
		apb(1, AC, 1);
		lock_ev(3'h4);
		apb(0, AS, 0);
		chk(rd[2:1], 1);
		apb(1, AC, 1);
		apb(1, A1, 0);
		@(posedge clk);
		ev <= 7'h0F;
		cyc(3);
		chk(flt, 1);
		chk({csf, ssf}, 0);
		// Drop the frequency event so only the timeout can pull the pin
		ev <= 7'h00;
		apb(1, A1, 7);
		@(posedge clk);
		ev <= 7'h0B;
		cyc(3);
		chk(flt, 0);
		chk({csf, ssf}, 3);
		ev <= 7'h00;
		apb(1, AC, 2);
		cyc(2);
		chk(flt, 1);
		ev <= 7'h04;
		cyc(3);
		chk(flt, 0);
		final_report;
	end
	initial begin
		cyc(30000);
		n_errors++;
		final_report;
	end
endmodule // motor_lock_fault_policy_test
